// ==== rtl/eipc_pkg.sv ====
/*
  Constants for the external interrupt pin, edge and enable control block:
  register addresses, writable masks, fixed read bits and timing figures.
  Assumes an 8-bit register port with a 16-bit byte address.
*/
package eipc_pkg;

  // Register addresses
  localparam logic [15:0] ADDR_PORT1_FUNC = 16'hFFEB;
  localparam logic [15:0] ADDR_EDGE_SEL   = 16'hFFF2;
  localparam logic [15:0] ADDR_EXT_EN     = 16'hFFF3;
  localparam logic [15:0] ADDR_TMR_EN     = 16'hFFF4;
  localparam logic [15:0] ADDR_PERIPH_EN  = 16'hFFF5;
  localparam logic [15:0] ADDR_EXT_PEND   = 16'hFFF6;
  localparam logic [15:0] ADDR_IRQ_STAT   = 16'hFFE0;
  localparam logic [15:0] ADDR_IRQ_MASK   = 16'hFFE1;

  // Writable bits of each register
  localparam logic [7:0] PORT1_FUNC_WMASK = 8'hF3;
  localparam logic [7:0] EDGE_SEL_WMASK   = 8'h13;
  localparam logic [7:0] EXT_EN_WMASK     = 8'h3F;
  localparam logic [7:0] TMR_EN_WMASK     = 8'hFF;
  localparam logic [7:0] PERIPH_EN_WMASK  = 8'hC3;
  localparam logic [3:0] IRQ_MASK_WMASK   = 4'hF;

  // Reserved bits that always read as one
  localparam logic [7:0] PORT1_FUNC_FIXED = 8'h0C;
  localparam logic [7:0] EDGE_SEL_FIXED   = 8'hEC;
  localparam logic [7:0] EXT_EN_FIXED     = 8'hC0;
  localparam logic [7:0] TMR_EN_FIXED     = 8'h00;
  localparam logic [7:0] PERIPH_EN_FIXED  = 8'h3C;
  localparam logic [7:0] EXT_PEND_FIXED   = 8'hC0;

  // Stored bits after reset, read data when idle or unmapped
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] RD_IDLE   = 8'h00;
  localparam logic [3:0] FLAG_RST  = 4'h0;
  // Pins idle high, so synchronisers and edge history start high
  localparam logic [3:0] PIN_RST   = 4'hF;

  // Bit positions
  localparam int unsigned NOISE_BIT = 7;
  localparam int unsigned EVENT_BIT = 6;
  localparam int unsigned SEL5_BIT  = 5;
  localparam int unsigned SEL4_BIT  = 4;
  localparam int unsigned SEL1_BIT  = 1;
  localparam int unsigned SEL0_BIT  = 0;
  localparam int unsigned DT_BIT    = 5;
  localparam int unsigned CONV_BIT  = 7;
  localparam int unsigned KEY_BIT   = 6;

  // Noise canceller sampling interval in clock states
  localparam int unsigned NOISE_PERIOD = 256;
  localparam logic [7:0]  NOISE_LAST   = 8'(NOISE_PERIOD - 1);
  localparam logic [7:0]  NOISE_CNT_RST = 8'h00;

endpackage

// ==== rtl/eipc_top.sv ====
/*
  External interrupt pin function, edge select and enable control.
  Holds the port-1 function select, edge select and three enable
  registers, the external pending flags, edge detection with a noise
  canceller on input 0, and gating of every request towards the CPU.
  Register map, all eight bits wide:
    function select   port pin or interrupt input per pin, noise
                      canceller enable for input 0, event pin mode
    edge select       falling (0) or rising (1) edge for inputs 4, 1, 0;
                      input 5 is always falling
    external enable   gates pending flags of inputs 5, 4, 1 and 0;
                      bits 3 and 2 are spare storage
    timer enable      direct-transfer and timer E..A gates; bits 7 and
                      6 are spare storage
    peripheral enable conversion end, key scan, serial 2 and 1 gates
    external pending  set by a selected edge, cleared by writing zero
    event status      sticky copy of edge events, cleared by reading
    event mask        selects which status bits drive irq
  Reserved bits that read one are not stored at all; the read path ORs
  in constants, so no write can ever disturb them.
  Timing, counted from a pin change:
    two cycles through the synchroniser, one for the edge compare,
    so the pending and status bits set on the third edge and irq
    rises with them; ext_req follows one edge later.
  With the noise canceller on, input 0 adds 257 to 512 cycles, since
  a level is only taken once two samples one period apart agree.
  Peripheral requests are the flag ANDed with its enable, one flop
  later; there is no priority here, that is the CPU's job.
  Assumes register strobes and peripheral pending flags come from
  logic on sys_clk; the four external pins are asynchronous.
  Assumes strobes are one cycle long and never both high together;
  a read answers in the next cycle and never stalls the master.
  Assumes software follows the safe pin-switch order: disable, switch,
  one spare access, clear the flag, enable again, since an old flag
  may still be set from before the switch.
*/
`timescale 1ns/10ps

module eipc_top
  import eipc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [15:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic       ext_int_pin_0,
  input  wire logic       ext_int_pin_1,
  input  wire logic       ext_int_pin_4,
  input  wire logic       ext_int_pin_5,
  input  wire logic       direct_transfer_pending,
  input  wire logic [4:0] timer_ovf_pending,
  input  wire logic       conv_end_pending,
  input  wire logic       key_scan_pending,
  input  wire logic       serial2_pending,
  input  wire logic       serial1_pending,
  output logic [7:0]      rd_data,
  output logic            irq,
  output logic [3:0]      ext_req,
  output logic            direct_transfer_req,
  output logic [4:0]      timer_ovf_req,
  output logic            conv_end_req,
  output logic            key_scan_req,
  output logic            serial2_req,
  output logic            serial1_req,
  output logic [3:0]      port1_irq_mode,
  output logic            event_pin_mode
);

  // Stored (writable) bits only; fixed bits are merged on read
  logic [7:0] port1_func_q;
  logic [7:0] edge_sel_q;
  logic [7:0] ext_en_q;
  logic [7:0] tmr_en_q;
  logic [7:0] periph_en_q;
  logic [3:0] pend_q;
  logic [3:0] pend_d;
  logic [3:0] stat_q;
  logic [3:0] stat_d;
  logic [3:0] mask_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic [3:0] prev_q;
  logic [7:0] noise_cnt_q;
  logic       noise_samp_q;
  logic       noise_filt_q;
  logic [7:0] rd_data_q;
  logic       irq_q;
  logic [3:0] ext_req_q;
  logic       dt_req_q;
  logic [4:0] tmr_req_q;
  logic       conv_req_q;
  logic       key_req_q;
  logic       ser2_req_q;
  logic       ser1_req_q;

  // Address decode
  // Exact 16-bit match; mirrors would hide software address bugs
  wire wr_func  = wr_en && (addr == ADDR_PORT1_FUNC);
  wire wr_edge  = wr_en && (addr == ADDR_EDGE_SEL);
  wire wr_exten = wr_en && (addr == ADDR_EXT_EN);
  wire wr_tmren = wr_en && (addr == ADDR_TMR_EN);
  wire wr_peren = wr_en && (addr == ADDR_PERIPH_EN);
  wire wr_pend  = wr_en && (addr == ADDR_EXT_PEND);
  wire wr_mask  = wr_en && (addr == ADDR_IRQ_MASK);
  wire rd_stat  = rd_en && (addr == ADDR_IRQ_STAT);

  // Per-input views, index 3..0 = inputs 5, 4, 1, 0
  // One packed order for every per-input vector keeps masks aligned
  wire [3:0] pin_raw = {ext_int_pin_5, ext_int_pin_4,
                        ext_int_pin_1, ext_int_pin_0};
  wire [3:0] pin_sel = {port1_func_q[SEL5_BIT], port1_func_q[SEL4_BIT],
                        port1_func_q[SEL1_BIT], port1_func_q[SEL0_BIT]};
  // Input 5 has no edge select and stays on falling edges
  wire [3:0] rise_sel = {1'b0, edge_sel_q[SEL4_BIT],
                         edge_sel_q[SEL1_BIT], edge_sel_q[SEL0_BIT]};
  wire [3:0] pend_en = {ext_en_q[SEL5_BIT], ext_en_q[SEL4_BIT],
                        ext_en_q[SEL1_BIT], ext_en_q[SEL0_BIT]};
  // Pending write bits: a zero clears, a one is ignored
  wire [3:0] pend_wr = {wdata[SEL5_BIT], wdata[SEL4_BIT],
                        wdata[SEL1_BIT], wdata[SEL0_BIT]};

  // Noise canceller on input 0
  // Filtered level replaces the synchronised one only while enabled
  wire noise_on   = port1_func_q[NOISE_BIT];
  wire noise_tick = (noise_cnt_q == NOISE_LAST);
  wire lvl0       = noise_on ? noise_filt_q : sync2_q[0];
  wire [3:0] lvl  = {sync2_q[3:1], lvl0};

  // Compared against the previous level, after sync or filter
  // Edge detection, only for pins in interrupt mode
  wire [3:0] fall = prev_q & ~lvl;
  wire [3:0] rise = ~prev_q & lvl;
  wire [3:0] edge_hit = pin_sel & ((rise_sel & rise) |
                                   (~rise_sel & fall));

  // Set wins over a clear in the same cycle
  // so an edge arriving while software clears is never lost
  assign pend_d = (pend_q & ~(wr_pend ? ~pend_wr : 4'h0))
                | edge_hit;
  assign stat_d = (rd_stat ? FLAG_RST : stat_q) | edge_hit;

  // Read values with reserved bits merged
  // Pending bits 3 and 2 have no storage and read zero
  wire [7:0] func_rd  = port1_func_q | PORT1_FUNC_FIXED;
  wire [7:0] edge_rd  = edge_sel_q | EDGE_SEL_FIXED;
  wire [7:0] exten_rd = ext_en_q | EXT_EN_FIXED;
  wire [7:0] tmren_rd = tmr_en_q | TMR_EN_FIXED;
  wire [7:0] peren_rd = periph_en_q | PERIPH_EN_FIXED;
  wire [7:0] pend_rd  = {2'b00, pend_q[3:2], 2'b00, pend_q[1:0]}
                      | EXT_PEND_FIXED;

  // Read multiplexer; unmapped addresses read as zero
  // Decoded from the address alone; rd_en only gates the flop
  wire [7:0] rd_mux =
    (addr == ADDR_PORT1_FUNC) ? func_rd  :
    (addr == ADDR_EDGE_SEL)   ? edge_rd  :
    (addr == ADDR_EXT_EN)     ? exten_rd :
    (addr == ADDR_TMR_EN)     ? tmren_rd :
    (addr == ADDR_PERIPH_EN)  ? peren_rd :
    (addr == ADDR_EXT_PEND)   ? pend_rd  :
    (addr == ADDR_IRQ_STAT)   ? {4'h0, stat_q} :
    (addr == ADDR_IRQ_MASK)   ? {4'h0, mask_q} : RD_IDLE;

  // Gated requests towards the CPU
  // Flag AND enable, evaluated every cycle; nothing is latched, so
  // clearing an enable drops the request on the next edge
  wire [3:0] ext_req_d = pend_q & pend_en;
  wire       dt_req_d  = direct_transfer_pending
                       & tmr_en_q[DT_BIT];
  wire [4:0] tmr_req_d = timer_ovf_pending & tmr_en_q[4:0];
  wire conv_req_d = conv_end_pending & periph_en_q[CONV_BIT];
  wire key_req_d  = key_scan_pending & periph_en_q[KEY_BIT];
  wire ser2_req_d = serial2_pending & periph_en_q[1];
  wire ser1_req_d = serial1_pending & periph_en_q[0];

  // Function select: bits 3 and 2 are never stored, they read fixed
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port1_func_q <= REG_RST;
    end else if (wr_func) begin
      port1_func_q <= wdata & PORT1_FUNC_WMASK;
    end
  end

  // Edge select: only bits 4, 1 and 0 hold state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      edge_sel_q <= REG_RST;
    end else if (wr_edge) begin
      edge_sel_q <= wdata & EDGE_SEL_WMASK;
    end
  end

  // External enable: spare bits 3 and 2 are kept as plain storage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_en_q <= REG_RST;
    end else if (wr_exten) begin
      ext_en_q <= wdata & EXT_EN_WMASK;
    end
  end

  // Timer and direct-transfer enable: every bit writable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tmr_en_q <= REG_RST;
    end else if (wr_tmren) begin
      tmr_en_q <= wdata & TMR_EN_WMASK;
    end
  end

  // Peripheral enable: bits 5 to 2 have no storage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      periph_en_q <= REG_RST;
    end else if (wr_peren) begin
      periph_en_q <= wdata & PERIPH_EN_WMASK;
    end
  end

  // Event mask: low four bits only, the rest read zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mask_q <= FLAG_RST;
    end else if (wr_mask) begin
      mask_q <= wdata[3:0] & IRQ_MASK_WMASK;
    end
  end

  // Two flops per pin; only the second stage is read by logic
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= PIN_RST;
      sync2_q <= PIN_RST;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  // Edge history follows the level even for port-mode pins,
  // so switching a pin to interrupt mode does not fake an edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prev_q <= PIN_RST;
    end else begin
      prev_q <= lvl;
    end
  end

  // Free-running sample timer; it never stops, so the first sample
  // after enabling the filter comes anywhere within one period
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      noise_cnt_q <= NOISE_CNT_RST;
    end else begin
      noise_cnt_q <= noise_cnt_q + 8'h01;
    end
  end

  // Sampler: the filtered level moves only when two samples agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      noise_samp_q <= 1'b1;
      noise_filt_q <= 1'b1;
    end else if (noise_tick) begin
      noise_samp_q <= sync2_q[0];
      if (sync2_q[0] == noise_samp_q) begin
        noise_filt_q <= sync2_q[0];
      end
    end
  end

  // Pending flags; the CPU taking the interrupt leaves them set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pend_q <= FLAG_RST;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Sticky event status, cleared by a read of its address
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stat_q <= FLAG_RST;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Read data stands for one cycle only, then returns to idle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_data_q <= RD_IDLE;
    end else begin
      rd_data_q <= rd_en ? rd_mux : RD_IDLE;
    end
  end

  // Uses the next status so irq rises with the status bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_d & mask_q);
    end
  end

  // External requests lag their pending flag by one cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ext_req_q <= FLAG_RST;
    end else begin
      ext_req_q <= ext_req_d;
    end
  end

  // Peripheral requests; registered so every output leaves a flop,
  // at the cost of one cycle of latency
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dt_req_q   <= 1'b0;
      tmr_req_q  <= 5'h00;
      conv_req_q <= 1'b0;
      key_req_q  <= 1'b0;
      ser2_req_q <= 1'b0;
      ser1_req_q <= 1'b0;
    end else begin
      dt_req_q   <= dt_req_d;
      tmr_req_q  <= tmr_req_d;
      conv_req_q <= conv_req_d;
      key_req_q  <= key_req_d;
      ser2_req_q <= ser2_req_d;
      ser1_req_q <= ser1_req_d;
    end
  end

  // Outputs straight from their flops
  assign rd_data             = rd_data_q;
  assign irq                 = irq_q;
  assign ext_req             = ext_req_q;
  assign direct_transfer_req = dt_req_q;
  assign timer_ovf_req       = tmr_req_q;
  assign conv_end_req        = conv_req_q;
  assign key_scan_req        = key_req_q;
  assign serial2_req         = ser2_req_q;
  assign serial1_req         = ser1_req_q;
  // Pin function straight from the select register
  assign port1_irq_mode      = pin_sel;
  assign event_pin_mode      = port1_func_q[EVENT_BIT];

endmodule

// ==== testbench/eipc_properties.sv ====
/*
  Port checker for eipc_top.
  Assumes one sys_clk domain and the async high rst.
*/
`timescale 1ns/10ps
module eipc_chk
  import eipc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [15:0] addr,
  input wire logic        rd_en,
  input wire logic [7:0]  rd_data,
  input wire logic        irq,
  input wire logic [3:0]  ext_req,
  input wire logic        direct_transfer_pending,
  input wire logic        direct_transfer_req,
  input wire logic [4:0]  timer_ovf_pending,
  input wire logic [4:0]  timer_ovf_req,
  input wire logic        conv_end_pending,
  input wire logic        conv_end_req,
  input wire logic        key_scan_pending,
  input wire logic        key_scan_req,
  input wire logic        serial1_pending,
  input wire logic        serial1_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Read data only in the cycle after a read
  AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == RD_IDLE)
    else $error("read data not idle");
  // Reserved bits read one
  AST_EDGE_FIXED: assert property ($past(rd_en) && $past(addr) == ADDR_EDGE_SEL
    |-> (rd_data & EDGE_SEL_FIXED) == EDGE_SEL_FIXED)
    else $error("edge select reserved bits");
  AST_PERIPH_FIXED: assert property ($past(rd_en) && $past(addr) ==
    ADDR_PERIPH_EN |-> (rd_data & PERIPH_EN_FIXED) == PERIPH_EN_FIXED)
    else $error("peripheral enable reserved bits");
  AST_EXT_EN_FIXED: assert property ($past(rd_en) && $past(addr) == ADDR_EXT_EN
    |-> rd_data[7:6] == 2'h3)
    else $error("external enable reserved bits");
  // No request without its pending flag
  AST_DT_GATE: assert property (!$past(direct_transfer_pending)
    |-> !direct_transfer_req)
    else $error("direct transfer request without flag");
  AST_TMR_GATE: assert property
    ((timer_ovf_req & ~$past(timer_ovf_pending)) == 5'h00)
    else $error("timer request without flag");
  AST_CONV_GATE: assert property (!conv_end_pending |=> !conv_end_req)
    else $error("conversion request without flag");
  AST_KEY_GATE: assert property (!key_scan_pending |=> !key_scan_req)
    else $error("key scan request without flag");
  AST_SER_GATE: assert property (!serial1_pending |=> !serial1_req)
    else $error("serial request without flag");
  COV_IRQ: cover property ($rose(irq));
  COV_EXT: cover property (ext_req[2]);
  COV_RD: cover property ($past(rd_en) && rd_data != 8'h00);
endmodule

bind eipc_top eipc_chk eipc_chk_inst (.sys_clk, .rst, .addr, .rd_en,
  .rd_data, .irq, .ext_req, .direct_transfer_pending, .direct_transfer_req,
  .timer_ovf_pending, .timer_ovf_req, .conv_end_pending, .conv_end_req,
  .key_scan_pending, .key_scan_req, .serial1_pending, .serial1_req);

// ==== testbench/eipc_cpu_model.sv ====
/*
  CPU side model: counts cycles with the interrupt line raised.
  Assumes irq is a level on sys_clk.
*/
`timescale 1ns/10ps
module eipc_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       irq,
  output logic      [7:0] accept_cnt_q
);
  // Saturates so a stuck line cannot wrap to zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) accept_cnt_q <= 8'h00;
    else if (irq && accept_cnt_q != 8'hFF) accept_cnt_q <= accept_cnt_q + 8'h01;
  end
endmodule

// ==== testbench/eipc_top_tb.sv ====
/*
  Self-checking bench for eipc_top.
  Assumes pins idle high and a 200 MHz sys_clk.
*/
`timescale 1ns/10ps
module eipc_top_tb
  import eipc_pkg::*;
;
  typedef struct {logic w; logic [15:0] a; logic [7:0] d, r;} eipc_row_t;
  logic        sys_clk, rst, wr_en, rd_en;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic [3:0]  pin;
  logic [9:0]  pend;
  wire  [7:0]  rd_data, acc;
  wire  [9:0]  req;
  wire  [3:0]  ereq, mode;
  wire         evt;
  wire         irq;
  int          mismatches = 0, num_checks = 0;
  eipc_row_t rows [18] = '{'{0, ADDR_PORT1_FUNC, 0, 8'h0C},
    '{0, ADDR_EDGE_SEL, 0, 8'hEC}, '{0, ADDR_EXT_EN, 0, 8'hC0},
    '{0, ADDR_TMR_EN, 0, 8'h00}, '{0, ADDR_PERIPH_EN, 0, 8'h3C},
    '{0, ADDR_EXT_PEND, 0, 8'hC0}, '{1, ADDR_PORT1_FUNC, 8'hFF, 8'hFF},
    '{1, ADDR_PORT1_FUNC, 0, 8'h0C}, '{1, ADDR_EDGE_SEL, 8'hFF, 8'hFF},
    '{1, ADDR_EDGE_SEL, 0, 8'hEC}, '{1, ADDR_EXT_EN, 0, 8'hC0},
    '{1, ADDR_EXT_EN, 8'h0C, 8'hCC}, '{1, ADDR_TMR_EN, 8'hC0, 8'hC0},
    '{1, ADDR_TMR_EN, 8'h3F, 8'h3F}, '{1, ADDR_PERIPH_EN, 0, 8'h3C},
    '{1, ADDR_PERIPH_EN, 8'hC3, 8'hFF}, '{1, ADDR_IRQ_MASK, 8'hFF, 8'h0F},
    '{1, 16'h0000, 8'hFF, 8'h00}};

  eipc_top eipc_top_inst (.sys_clk(sys_clk), .rst(rst), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .ext_int_pin_0(pin[0]),
    .ext_int_pin_1(pin[1]), .ext_int_pin_4(pin[2]), .ext_int_pin_5(pin[3]),
    .direct_transfer_pending(pend[9]), .timer_ovf_pending(pend[8:4]),
    .conv_end_pending(pend[3]), .key_scan_pending(pend[2]),
    .serial2_pending(pend[1]), .serial1_pending(pend[0]),
    .rd_data(rd_data), .irq(irq), .ext_req(ereq),
    .direct_transfer_req(req[9]), .timer_ovf_req(req[8:4]),
    .conv_end_req(req[3]), .key_scan_req(req[2]), .serial2_req(req[1]),
    .serial1_req(req[0]), .port1_irq_mode(mode), .event_pin_mode(evt));
  eipc_cpu_model eipc_cpu_model_inst (.sys_clk(sys_clk), .rst(rst),
    .irq(irq), .accept_cnt_q(acc));

  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr_en <= 1; addr <= a; wdata <= d;
    @(posedge sys_clk);
    wr_en <= 0;
  endtask
  // Data sampled just after the edge that answers
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    rd_en <= 1; addr <= a;
    @(posedge sys_clk);
    rd_en <= 0;
    #1 chk(rd_data, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait, pins reach irq in three cycles
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    if (n == 8) begin
      mismatches++;
      print_verdict();
    end
  endtask

  initial begin
    rst = 1; addr = 0; wdata = 0; wr_en = 0; rd_en = 0;
    pin = 4'hF; pend = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].r);
    end
    pend <= 10'h3FF;
    cyc(2);
    chk(req, 10'h3FF);
    wr(ADDR_TMR_EN, 8'h15);
    wr(ADDR_PERIPH_EN, 8'h81);
    cyc(2);
    chk(req, 10'h159);
    pend <= 0;
    cyc(2);
    chk(req, 10'h000);
    pin[0] <= 0;
    cyc(5);
    rd(ADDR_EXT_PEND, 8'hC0);
    pin[0] <= 1;
    wr(ADDR_PORT1_FUNC, 8'h01);
    wr(ADDR_EXT_EN, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    cyc(5);
    pin[0] <= 0;
    wait_irq();
    // Request flop follows irq by one edge
    cyc(1);
    chk(ereq, 4'h1);
    rd(ADDR_EXT_PEND, 8'hC1);
    wr(ADDR_EXT_PEND, 8'hFF);
    rd(ADDR_EXT_PEND, 8'hC1);
    rd(ADDR_IRQ_STAT, 8'h01);
    chk(irq, 1'b0);
    wr(ADDR_EXT_PEND, 8'h00);
    cyc(2);
    chk(ereq, 4'h0);
    // Rising edge with the interrupt masked
    wr(ADDR_EDGE_SEL, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    pin[0] <= 1;
    cyc(6);
    chk({irq, ereq}, 5'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    cyc(2);
    chk(irq, 1'b1);
    rd(ADDR_IRQ_STAT, 8'h01);
    chk(irq, 1'b0);
    // Pin switch: disable, switch, clear the flag, enable again, with no spare access
    wr(ADDR_EXT_EN, 8'h00);
    wr(ADDR_PORT1_FUNC, 8'h10);
    wr(ADDR_EXT_PEND, 8'h00);
    wr(ADDR_EXT_EN, 8'h10);
    pin <= 4'hA;
    cyc(6);
    chk(ereq, 4'h4);
    chk(16'(acc != 8'h00), 16'h1);
    wr(ADDR_PORT1_FUNC, 8'h61);
    cyc(1);
    chk({evt, mode}, 5'h19);
    // Noise filter: a short glitch is dropped, a held level is taken
    wr(ADDR_PORT1_FUNC, 8'h81);
    wr(ADDR_EDGE_SEL, 8'h00);
    pin <= 4'hF;
    cyc(600);
    wr(ADDR_EXT_PEND, 8'h00);
    pin[0] <= 0;
    cyc(3);
    pin[0] <= 1;
    cyc(600);
    rd(ADDR_EXT_PEND, 8'hC0);
    pin[0] <= 0;
    cyc(600);
    rd(ADDR_EXT_PEND, 8'hC1);
    wr(ADDR_EXT_EN, 8'h01);
    pend <= 10'h3FF;
    cyc(2);
    chk(ereq, 4'h1);
    // Reset in mid-run clears flags, enables and requests
    rst <= 1;
    cyc(2);
    chk({irq, ereq, rd_data}, 16'h0000);
    chk(req, 10'h000);
    rst <= 0;
    rd(ADDR_EXT_EN, 8'hC0);
    chk(req, 10'h000);
    print_verdict();
  end
endmodule
